// ---- design/fppm_pin_mux.v ----
// Operation
// RULE1 - mode field routes porta 4-6, port b
// RULE2 - port function is bidirectional port bit
// RULE3 - two address selects choose fifo
// RULE4 - packet commit input commits selected fifo
// RULE5 - packet commit polarity is polarity bit 5
// RULE6 - porta bit7: port, flag d, chip select
// RULE7 - flag d drives programmable fifo status
// RULE8 - deasserted chip select gates all strobes
// RULE9 - port b carries data bits 0-7
// RULE10 - port d carries upper data when wide
// RULE11 - flag b defaults to selected fifo full
// RULE12 - output enable polarity is polarity bit 4
// RULE13 - reset leaves pins as port inputs
`include "fppm_map.vh"
module fppm_pin_mux #(
  parameter NFIFO  = 4,
  parameter DWID   = 16,
  parameter PD_W   = 5
) (
  // clock and reset
  input  wire                       i_mclk,
  input  wire                       i_rstn,
  // configuration
  input  wire [`FPPM_IFMODE_W-1:0]  i_interface_config,
  input  wire [`FPPM_PACFG_W-1:0]   i_port_a_config,
  input  wire [`FPPM_POL_W-1:0]     i_fifo_pin_polarity,
  input  wire [NFIFO-1:0]           i_endpoint_fifo_config_wide,
  // port logic side
  input  wire [3:0]                 i_porta_out,
  input  wire [3:0]                 i_porta_oe,
  input  wire [7:0]                 i_portb_out,
  input  wire [7:0]                 i_portb_oe,
  input  wire [PD_W-1:0]            i_portd_out,
  input  wire [PD_W-1:0]            i_portd_oe,
  output reg  [3:0]                 o_porta_in,
  output reg  [7:0]                 o_portb_in,
  output reg  [PD_W-1:0]            o_portd_in,
  // fifo core side
  input  wire [NFIFO-1:0]           i_fifo_full,
  input  wire [NFIFO-1:0]           i_flag_d_status,
  input  wire                       i_fifo_oe_pin,
  input  wire                       i_fifo_drive,
  input  wire [7+PD_W:0]            i_fifo_wdata,
  output reg  [1:0]                 o_fifo_sel,
  output reg                        o_packet_commit,
  output reg                        o_fifo_out_enable,
  output reg                        o_chip_selected,
  output reg                        o_fifo_status_flag_b,
  output reg  [7+PD_W:0]            o_fifo_rdata,
  output reg                        o_wide_active,
  // pads
  input  wire [3:0]                 i_porta_pad,
  output wire [3:0]                 o_porta_pad,
  output wire [3:0]                 o_porta_pad_oe,
  input  wire [7:0]                 i_portb_pad,
  output wire [7:0]                 o_portb_pad,
  output wire [7:0]                 o_portb_pad_oe,
  input  wire [PD_W-1:0]            i_portd_pad,
  output wire [PD_W-1:0]            o_portd_pad,
  output wire [PD_W-1:0]            o_portd_pad_oe
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  localparam ST_PORT = 3'b001;
  localparam ST_WAVE = 3'b010;
  localparam ST_FIFO = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;

  always @*
  begin
    case (i_interface_config)                                   // [RULE1]
      `FPPM_IFMODE_FIFO: state_next = ST_FIFO;
      `FPPM_IFMODE_WAVE: state_next = ST_WAVE;
      default:           state_next = ST_PORT;
    endcase
  end

  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      state_reg <= ST_PORT;                                     // [RULE13]
    else
      state_reg <= state_next;
  end

  wire fifo_mode = state_reg[2];
  wire data_mode = state_reg[2] | state_reg[1];                 // [RULE9]
  wire pa7_alt   = i_port_a_config[`FPPM_PACFG_PA7_BIT];
  wire pa7_cs    = fifo_mode & ~pa7_alt;                        // [RULE6]
  wire pa7_flag  = fifo_mode & pa7_alt;                         // [RULE6]

  // ----------------------------------------
  // sampled pin inputs
  // ----------------------------------------
  wire [3:0]      pa_in;
  wire [7:0]      pb_in;
  wire [PD_W-1:0] pd_in;
  wire [1:0]      addr_sel = pa_in[1:0];
  wire            commit_act;
  wire            oe_act;
  wire            cs_active = ~pa7_cs | ~pa_in[3];              // [RULE8]
  wire            wide_sel  = i_endpoint_fifo_config_wide[addr_sel];
  wire            wide_now  = fifo_mode & wide_sel;             // [RULE10]
  reg             flag_d;

  fppm_pol_in u_commit_pol (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_raw      (pa_in[2]),
    .i_act_high (i_fifo_pin_polarity[`FPPM_POL_PACKET_COMMIT_IN_BIT]),    // [RULE5]
    .o_active   (commit_act)
  );

  fppm_pol_in u_oe_pol (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_raw      (i_fifo_oe_pin),
    .i_act_high (i_fifo_pin_polarity[`FPPM_POL_OE_BIT]),        // [RULE12]
    .o_active   (oe_act)
  );

  always @*
  begin
    flag_d = i_flag_d_status[addr_sel];                         // [RULE7]
  end

  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pa
      wire alt = (g == 3) ? (pa7_cs | pa7_flag) : fifo_mode;    // [RULE1] [RULE6]
      fppm_pin_cell u_cell (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_alt_sel  (alt),
        .i_port_out (i_porta_out[g]),                           // [RULE2]
        .i_port_oe  (i_porta_oe[g]),
        .i_alt_out  ((g == 3) ? flag_d : 1'b0),
        .i_alt_oe   ((g == 3) ? pa7_flag : 1'b0),               // [RULE3] [RULE7]
        .i_pad_in   (i_porta_pad[g]),
        .o_pad_out  (o_porta_pad[g]),
        .o_pad_oe   (o_porta_pad_oe[g]),
        .o_in       (pa_in[g])
      );
    end
    for (g = 0; g < 8; g = g + 1)
    begin : g_pb
      fppm_pin_cell u_cell (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_alt_sel  (data_mode),                                // [RULE9]
        .i_port_out (i_portb_out[g]),                           // [RULE2]
        .i_port_oe  (i_portb_oe[g]),
        .i_alt_out  (i_fifo_wdata[g]),
        .i_alt_oe   (i_fifo_drive & cs_active & oe_act),        // [RULE8]
        .i_pad_in   (i_portb_pad[g]),
        .o_pad_out  (o_portb_pad[g]),
        .o_pad_oe   (o_portb_pad_oe[g]),
        .o_in       (pb_in[g])
      );
    end
    for (g = 0; g < PD_W; g = g + 1)
    begin : g_pd
      fppm_pin_cell u_cell (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_alt_sel  (wide_now),                                 // [RULE10]
        .i_port_out (i_portd_out[g]),                           // [RULE2]
        .i_port_oe  (i_portd_oe[g]),
        .i_alt_out  (i_fifo_wdata[8+g]),
        .i_alt_oe   (i_fifo_drive & cs_active & oe_act),        // [RULE8]
        .i_pad_in   (i_portd_pad[g]),
        .o_pad_out  (o_portd_pad[g]),
        .o_pad_oe   (o_portd_pad_oe[g]),
        .o_in       (pd_in[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_porta_in           <= 4'h0;
      o_portb_in           <= 8'h00;
      o_portd_in           <= {PD_W{1'b0}};
      o_fifo_sel           <= 2'h0;
      o_packet_commit      <= 1'b0;
      o_fifo_out_enable    <= 1'b0;
      o_chip_selected      <= 1'b0;
      o_fifo_status_flag_b <= 1'b0;
      o_fifo_rdata         <= {(8+PD_W){1'b0}};
      o_wide_active        <= 1'b0;
    end
    else
    begin
      o_porta_in           <= pa_in;
      o_portb_in           <= pb_in;
      o_portd_in           <= pd_in;
      o_fifo_sel           <= fifo_mode ? addr_sel : 2'h0;      // [RULE3]
      o_packet_commit      <= fifo_mode & cs_active & commit_act; // [RULE4] [RULE8]
      o_fifo_out_enable    <= fifo_mode & cs_active & oe_act;   // [RULE8] [RULE12]
      o_chip_selected      <= fifo_mode & cs_active;
      o_fifo_status_flag_b <= i_fifo_full[addr_sel];            // [RULE11]
      o_fifo_rdata         <= {wide_now ? pd_in : {PD_W{1'b0}}, pb_in};
      o_wide_active        <= wide_now;
    end
  end
endmodule // fppm_pin_mux

// ---- design/fppm_map.vh ----
`ifndef FPPM_MAP_VH
`define FPPM_MAP_VH
// ----------------------------------------
// interface mode field encodings
// ----------------------------------------
`define FPPM_IFMODE_W        2
`define FPPM_IFMODE_PORTS    2'h0
`define FPPM_IFMODE_RSVD     2'h1
`define FPPM_IFMODE_WAVE     2'h2
`define FPPM_IFMODE_FIFO     2'h3
// ----------------------------------------
// configuration bit positions
// ----------------------------------------
`define FPPM_POL_PACKET_COMMIT_IN_BIT  5
`define FPPM_POL_OE_BIT      4
`define FPPM_POL_W           6
`define FPPM_PACFG_PA7_BIT   7
`define FPPM_PACFG_W         8
`define FPPM_EPCFG_WIDE_BIT  0
// ----------------------------------------
// reset values
// ----------------------------------------
`define FPPM_RST_BYTE        8'h00
`define FPPM_RST_BIT         1'b0
`endif

// ---- design/fppm_pin_cell.v ----
// generic muxed pin: port function or alternate function
module fppm_pin_cell (
  // clock and reset
  input  wire i_mclk,
  input  wire i_rstn,
  // selection
  input  wire i_alt_sel,
  // port function
  input  wire i_port_out,
  input  wire i_port_oe,
  // alternate function
  input  wire i_alt_out,
  input  wire i_alt_oe,
  // pad
  input  wire i_pad_in,
  output wire o_pad_out,
  output wire o_pad_oe,
  output wire o_in
);
  reg out_reg;
  reg oe_reg;
  reg in_reg;

  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
      in_reg  <= 1'b0;
    end
    else
    begin
      out_reg <= i_alt_sel ? i_alt_out : i_port_out;
      oe_reg  <= i_alt_sel ? i_alt_oe : i_port_oe;
      in_reg  <= i_pad_in;
    end
  end

  assign o_pad_out = out_reg;
  assign o_pad_oe  = oe_reg;
  assign o_in      = in_reg;
endmodule // fppm_pin_cell

// ---- design/fppm_pol_in.v ----
// programmable-polarity input, returns active-high level
module fppm_pol_in (
  input  wire i_mclk,
  input  wire i_rstn,
  input  wire i_raw,
  input  wire i_act_high,
  output wire o_active
);
  reg act_reg;

  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      act_reg <= 1'b0;
    else
      act_reg <= i_act_high ? i_raw : ~i_raw;
  end

  assign o_active = act_reg;
endmodule // fppm_pol_in

// ---- dv/fppm_checker.sv ----
module fppm_checker #(parameter PD_W = 5) (
  input wire i_mclk, i_rstn, i_fifo_oe_pin, i_fifo_drive,
  input wire [1:0] i_interface_config,
  input wire [7:0] i_port_a_config, i_portb_oe, i_portb_out, i_portb_pad,
  input wire [5:0] i_fifo_pin_polarity,
  input wire [3:0] i_endpoint_fifo_config_wide, i_porta_oe, i_fifo_full, i_flag_d_status, i_porta_pad,
  input wire [7+PD_W:0] i_fifo_wdata,
  input wire [1:0] o_fifo_sel,
  input wire o_packet_commit, o_fifo_out_enable, o_fifo_status_flag_b, o_wide_active, o_chip_selected,
  input wire [3:0] o_porta_pad, o_porta_pad_oe,
  input wire [7:0] o_portb_pad, o_portb_pad_oe, o_portb_in,
  input wire [PD_W-1:0] o_portd_pad_oe
);
  // ---
  // input quiet counter
  // ---
  logic [69+PD_W:0] cat, cat_reg;
  logic [2:0] q_reg;
  assign cat = {i_interface_config, i_port_a_config, i_fifo_pin_polarity, i_endpoint_fifo_config_wide,
    i_portb_oe, i_portb_out, i_portb_pad, i_fifo_full, i_flag_d_status, i_porta_pad, i_porta_oe,
    i_fifo_oe_pin, i_fifo_drive, i_fifo_wdata};
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      cat_reg <= '0;
      q_reg   <= 3'h0;
    end
    else
    begin
      cat_reg <= cat;
      q_reg   <= (cat != cat_reg) ? 3'h0 : ((q_reg == 3'h2) ? q_reg : q_reg + 3'h1);
    end
  // inputs unchanged over the last three edges, deepest path is three flops
  wire st = (q_reg == 3'h2) && (cat == cat_reg);
  wire fm = (i_interface_config == 2'h3);
  wire cs = i_port_a_config[7] | ~i_porta_pad[3];
  wire oe_ok = (i_fifo_oe_pin == i_fifo_pin_polarity[4]);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_reset_pins_in: assert property ($rose(i_rstn) |->
    !(|{o_porta_pad_oe, o_portb_pad_oe, o_portd_pad_oe})) else $error("pad driven after reset");
  a_port_follow: assert property (st && !i_interface_config[1] |-> o_portb_pad_oe == i_portb_oe &&
    (o_portb_pad & i_portb_oe) == (i_portb_out & i_portb_oe) && o_porta_pad_oe == i_porta_oe &&
    o_portb_in == i_portb_pad) else $error("port function broken");
  a_addr_sel: assert property (st |-> o_fifo_sel == (fm ? i_porta_pad[1:0] : 2'h0))
    else $error("fifo select wrong");
  a_pa_dir: assert property (st && fm |-> o_porta_pad_oe == {i_port_a_config[7], 3'h0})
    else $error("port a direction wrong");
  a_flag_d: assert property (st && fm && i_port_a_config[7] |->
    o_porta_pad[3] == i_flag_d_status[i_porta_pad[1:0]]) else $error("flag d wrong");
  a_flag_b: assert property (st && fm |-> o_fifo_status_flag_b == i_fifo_full[i_porta_pad[1:0]])
    else $error("flag b wrong");
  a_commit_pol: assert property (st && fm |->
    o_packet_commit == (cs && i_porta_pad[2] == i_fifo_pin_polarity[5])) else $error("commit wrong");
  a_oe_pol: assert property (st && fm |-> o_fifo_out_enable == (cs && oe_ok))
    else $error("out enable wrong");
  a_chip_sel: assert property (st && fm |-> o_chip_selected == cs)
    else $error("chip select wrong");
  a_data_drive: assert property (st && fm |-> o_portb_pad_oe == {8{i_fifo_drive & cs & oe_ok}} &&
    (o_portb_pad_oe & (o_portb_pad ^ i_fifo_wdata[7:0])) == 8'h00) else $error("data drive wrong");
  a_wide_sel: assert property (st |->
    o_wide_active == (fm && i_endpoint_fifo_config_wide[i_porta_pad[1:0]])) else $error("wide select wrong");
endmodule // fppm_checker

// ---- dv/fppm_ext_master.sv ----
module fppm_ext_master (
  input  logic       i_mclk,
  input  logic [3:0] i_cmd,
  input  logic       i_data_en,
  input  logic [7:0] i_data,
  input  wire  [3:0] i_pa_dev, i_pa_oe,
  input  wire  [7:0] i_pb_dev, i_pb_oe,
  output logic [3:0] o_pa_pad,
  output logic [7:0] o_pb_pad
);
  logic [7:0] last_reg = 8'h00;
  always @(posedge i_mclk) last_reg <= o_pb_pad;
  // selects, commit and chip select driven by the master on every line the device leaves released
  assign o_pa_pad = (i_pa_oe & i_pa_dev) | (~i_pa_oe & i_cmd);
  // released data lines carry i_data while i_data_en is set, otherwise toggle instead of holding
  assign o_pb_pad = (i_pb_oe & i_pb_dev) | (~i_pb_oe & (i_data_en ? i_data : ~last_reg));
endmodule // fppm_ext_master

// ---- dv/fppm_tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_fifo_oe_pin = 1'b0, i_fifo_drive = 1'b0, men = 1'b1;
  logic [1:0] i_interface_config = '0;
  logic [7:0] i_port_a_config = '0, i_portb_out = '0, i_portb_oe = '0, mdata = '0;
  logic [5:0] i_fifo_pin_polarity = '0;
  logic [3:0] i_endpoint_fifo_config_wide = '0, i_porta_out = '0, i_porta_oe = '0, i_fifo_full = '0;
  logic [3:0] i_flag_d_status = '0, mcmd = 4'h8;
  logic [4:0] i_portd_out = '0, i_portd_oe = '0, i_portd_pad = '0;
  logic [12:0] i_fifo_wdata = '0;
  wire [3:0] i_porta_pad, o_porta_pad, o_porta_pad_oe, o_porta_in;
  wire [7:0] i_portb_pad, o_portb_pad, o_portb_pad_oe, o_portb_in;
  wire [4:0] o_portd_pad, o_portd_pad_oe, o_portd_in;
  wire [1:0] o_fifo_sel;
  wire [12:0] o_fifo_rdata;
  wire o_packet_commit, o_fifo_out_enable, o_chip_selected, o_fifo_status_flag_b, o_wide_active;
  int n_errors = 0, checked = 0;
  always #4 i_mclk = ~i_mclk;
  fppm_pin_mux fppm_pin_mux_i (.*);
  fppm_ext_master fppm_ext_master_i (.i_mclk(i_mclk), .i_cmd(mcmd), .i_data_en(men), .i_data(mdata),
    .i_pa_dev(o_porta_pad), .i_pa_oe(o_porta_pad_oe), .i_pb_dev(o_portb_pad), .i_pb_oe(o_portb_pad_oe),
    .o_pa_pad(i_porta_pad), .o_pb_pad(i_portb_pad));
  task chk(input string nm, input logic [12:0] s, input logic [12:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_reset;
    chk("pad oe", {o_portd_pad_oe, o_portb_pad_oe}, 13'h0000);
    chk("porta oe", o_porta_pad_oe, 13'h0000);
    $display("test reset done");
  endtask
  task t_ports;
    {i_portb_oe, i_portb_out, mdata, i_porta_oe} = {8'h5a, 8'h3c, 8'hc3, 4'h3};
    for (int m = 0; m < 2; m++)
    begin
      i_interface_config = m[1:0];
      step(4);
      chk("portb oe", o_portb_pad_oe, 13'h005a);
      chk("portb out", o_portb_pad & 8'h5a, 13'h0018);
      chk("portb in", o_portb_in, 13'h0099);
      chk("porta oe", o_porta_pad_oe, 13'h0003);
      chk("porta in", o_porta_in, 13'h0008);
    end
    {i_portb_oe, i_porta_oe} = '0;
    $display("test ports done");
  endtask
  task t_flags;
    {i_interface_config, i_port_a_config, i_fifo_pin_polarity} = {2'h3, 8'h80, 6'h20};
    {i_fifo_full, i_flag_d_status} = {4'h9, 4'h6};
    for (int a = 0; a < 4; a++)
    begin
      mcmd = {2'b10, a[1:0]};
      step(4);
      chk("sel", o_fifo_sel, a);
      chk("flag b", o_fifo_status_flag_b, i_fifo_full[a]);
      chk("flag d", o_porta_pad[3], i_flag_d_status[a]);
      chk("pa oe", o_porta_pad_oe, 13'h0008);
    end
    $display("test flags done");
  endtask
  task t_commit;
    i_port_a_config = 8'h00;
    for (int p = 0; p < 2; p++)
    begin
      {i_fifo_pin_polarity, i_fifo_oe_pin, mcmd} = {p[0], p[0], 4'h0, p[0], 1'b0, p[0], 2'h1};
      step(4);
      chk("commit", o_packet_commit, 13'h0001);
      chk("out en", o_fifo_out_enable, 13'h0001);
      chk("chip sel", o_chip_selected, 13'h0001);
      mcmd[3] = 1'b1;
      step(4);
      chk("commit cs", o_packet_commit, 13'h0000);
      chk("out en cs", o_fifo_out_enable, 13'h0000);
      chk("chip sel off", o_chip_selected, 13'h0000);
      {i_fifo_oe_pin, mcmd} = {~p[0], 1'b0, ~p[0], 2'h1};
      step(4);
      chk("commit idle", o_packet_commit, 13'h0000);
      chk("out en idle", o_fifo_out_enable, 13'h0000);
    end
    $display("test commit done");
  endtask
  task t_data;
    {i_fifo_pin_polarity, i_fifo_oe_pin, i_endpoint_fifo_config_wide, mdata} = {6'h10, 1'b1, 4'h2, 8'ha5};
    {i_portd_pad, i_portd_oe, i_portd_out, mcmd} = {5'h1b, 5'h1f, 5'h0a, 4'h0};
    step(4);
    chk("rdata narrow", o_fifo_rdata, 13'h00a5);
    chk("portd narrow", o_portd_pad_oe, 13'h001f);
    chk("portd out", o_portd_pad, 13'h000a);
    chk("portd in", o_portd_in, 13'h001b);
    mcmd = 4'h1;
    step(4);
    chk("wide", o_wide_active, 13'h0001);
    chk("rdata wide", o_fifo_rdata, 13'h1ba5);
    chk("portd wide", o_portd_pad_oe, 13'h0000);
    {men, i_fifo_drive, i_fifo_wdata} = {2'b01, 13'h15a6};
    step(4);
    chk("drive", {o_portd_pad_oe, o_portb_pad_oe}, 13'h1fff);
    chk("wdata", {o_portd_pad, o_portb_pad}, 13'h15a6);
    mcmd = 4'h9;
    step(4);
    chk("drive cs", o_portb_pad_oe, 13'h0000);
    $display("test data done");
  endtask
  task t_mid_reset;
    {men, mcmd} = {1'b1, 4'h1};
    step(4);
    chk("drive on", o_portb_pad_oe, 13'h00ff);
    i_rstn = 1'b0;
    step(2);
    chk("oe in reset", {o_portd_pad_oe, o_portb_pad_oe}, 13'h0000);
    chk("cs in reset", o_chip_selected, 13'h0000);
    i_rstn = 1'b1;
    step(1);
    chk("oe after reset", o_portb_pad_oe, 13'h0000);
    step(2);
    chk("oe mode kept", o_portb_pad_oe, 13'h00ff);
    $display("test mid reset done");
  endtask
  initial
  begin
    repeat (4) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    step(1);
    t_reset;
    t_ports;
    t_flags;
    t_commit;
    t_data;
    t_mid_reset;
    finish_test;
  end
  initial
  begin
    #20000;
    n_errors++;
    finish_test;
  end
endmodule // tb
bind fppm_pin_mux fppm_checker #(.PD_W(PD_W)) fppm_checker_i (.*);
